/* include/fgen_pkg.sv */
// constants for the t1 transmit frame generator control block
package fgen_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FORMAT = 8'h60;
  localparam logic [7:0] IDX_MODE = 8'h62;
  localparam logic [7:0] IDX_SLC_C_LO = 8'h65;
  localparam logic [7:0] IDX_SLC_MC_HI = 8'h66;
  localparam logic [7:0] IDX_SLC_SA = 8'h67;
  localparam logic [7:0] IDX_YELLOW = 8'h6b;
  localparam logic [7:0] IDX_OVERRIDE = 8'h6c;
  localparam logic [7:0] IDX_IRQ_EN = 8'h6d;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'h6e;
  // reset values
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_SLC = 8'h00;
  localparam logic [7:0] RST_YELLOW = 8'h00;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAG = 8'h00;
  // writable bits of each register
  localparam logic [7:0] MASK_FORMAT = 8'h07;
  localparam logic [7:0] MASK_MODE = 8'h07;
  localparam logic [7:0] MASK_SLC_C_LO = 8'hff;
  localparam logic [7:0] MASK_SLC_HI = 8'h3f;
  localparam logic [7:0] MASK_YELLOW = 8'h30;
  localparam logic [7:0] MASK_OVERRIDE = 8'h0f;
  localparam logic [7:0] MASK_IRQ = 8'h30;
  // field positions
  localparam int B_J1 = 2;
  localparam int B_FRAME_GEN_DISABLE = 0;
  localparam int B_CRC_BYPASS = 1;
  localparam int B_DL_BYPASS = 2;
  localparam int B_MAN_YEL = 4;
  localparam int B_AUTO_YEL = 5;
  localparam int B_FORCE_ONE = 0;
  localparam int B_FORCE_ZERO = 1;
  localparam int B_SLIP = 2;
  localparam int B_FCOPY = 3;
  localparam int B_BF = 4;
  localparam int B_MF = 5;
  // framing formats, low two bits of the format register
  typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC} format_e;
  // frame layout
  localparam logic [7:0] LAST_BIT = 8'hc0;
  localparam logic [7:0] D_BIT_POS = 8'hbe;
  localparam logic [6:0] LAST_FRM_12 = 7'h0b;
  localparam logic [6:0] LAST_FRM_ESF = 7'h17;
  localparam logic [6:0] LAST_FRM_SLC = 7'h47;
  // patterns are stored first-sent bit in bit 0
  localparam logic [5:0] FS_PAT = 6'h1c;
  localparam logic [5:0] FAS_PAT = 6'h34;
  localparam logic [11:0] SLC_SYNC = 12'he38;
  localparam logic [5:0] SLC_C0 = 6'h0c;
  localparam logic [5:0] SLC_SPARE = 6'h17;
  localparam logic [5:0] SLC_M0 = 6'h18;
  localparam logic [5:0] SLC_A0 = 6'h1b;
  localparam logic [5:0] SLC_S0 = 6'h1d;
  localparam logic [5:0] SLC_END = 6'h21;
  // data link codes, sent msb first
  localparam logic [15:0] IDLE_T1 = 16'hffff;
  localparam logic [15:0] IDLE_J1 = 16'hff7e;
  localparam logic [15:0] YEL_ESF = 16'hff00;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/crc6_gen.sv */
// serial crc-6 accumulator for esf multiframes
`timescale 1ns/10ps
`default_nettype none
module crc6_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic restart,
  input wire logic din,
  output logic [5:0] crc
);
  logic [5:0] next_crc;
  logic [5:0] base;
  logic fb;

  // restart drops the old remainder so the first bit seeds a new one
  always_comb begin
    base = restart ? 6'h00 : crc;
    fb = din ^ base[5];
    next_crc = crc;
    if (en) begin
      next_crc = {base[4:0], 1'b0} ^ (fb ? fgen_pkg::CRC_POLY : 6'h00);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc <= 6'h00;
    end else begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

/* core/t1_frame_gen.sv */
// t1/j1 transmit frame generator with its axi4-lite register file
//
// What this block does
// - frame-disable 1 stops framing and every framing-dependent insertion; 0 frames.
// - esf without bypass puts codes, hdlc data or idle ffff/ff7e on dl bits.
// - t1 dm without bypass overwrites bit 6 of channel 24 with hdlc data.
// - slc-96 without bypass replaces c, m, a and s bits from registers.
// - esf without crc bypass inserts previous multiframe crc-6 in frames 2,6,10...
// - the eleven concentrator bits go out bit 1 first, bit 11 last.
// - maintenance bits go out beginning with bit 1.
// - switch bits go out beginning with bit 1.
// - alarm bits go out beginning with bit 1.
// - auto yellow enabled inserts yellow while a received red alarm stands.
// - manual yellow set inserts yellow regardless of receive conditions.
// - mimic enabled copies each f bit into the bit after it.
// - a toggle of the slip control shifts alignment by one bit; toggles before the next strobe make one shift.
// - force-zero forces every outgoing bit to zero.
// - force-one forces every outgoing bit to one unless force-zero is also set.
// - multiframe flag drives the interrupt only when its enable is set.
// - basic-frame flag drives the interrupt only when its enable is set.
// - multiframe flag sets on each multiframe's first bit, clears on write one.
// - basic-frame flag sets on each frame's first bit, clears on write one.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module t1_frame_gen #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TX_BIT_STB,
  input wire logic TX_DATA,
  input wire logic DL_BIT,
  input wire logic DL_ACTIVE,
  input wire logic RX_RED,
  output logic TX_LINE_DATA,
  output logic TX_LINE_STB,
  output logic INT_N
);
  localparam int BF = fgen_pkg::B_BF;
  localparam int MF = fgen_pkg::B_MF;

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic have_aw, have_w, aw_hit, wen, bvalid, awready, wready, arready, rvalid;
  logic next_have_aw, next_have_w, next_aw_hit, next_wen, next_bvalid;
  logic next_awready, next_wready, next_arready, next_rvalid;
  logic [7:0] aw_idx, wbyte, rdata, next_aw_idx, next_wbyte, next_rdata;
  logic [1:0] bresp, rresp, next_bresp, next_rresp;
  logic [7:0] fmt_r, mode_r, clo_r, mchi_r, sa_r, yel_r, ovr_r, irqen_r;
  logic [7:0] next_fmt, next_mode, next_clo, next_mchi, next_sa;
  logic [7:0] next_yel, next_ovr, next_irqen, flag_clr;
  logic [7:0] flags;
  logic [8:0] rd_word, aw_word;

  // read mux: hit bit on top of the byte; unmapped reads return slverr
  function automatic logic [8:0] rd_mux(input logic [7:0] i);
    logic [8:0] r;
    r = 9'h000;
    case (i)
      fgen_pkg::IDX_FORMAT: r = {1'b1, fmt_r};
      fgen_pkg::IDX_MODE: r = {1'b1, mode_r};
      fgen_pkg::IDX_SLC_C_LO: r = {1'b1, clo_r};
      fgen_pkg::IDX_SLC_MC_HI: r = {1'b1, mchi_r};
      fgen_pkg::IDX_SLC_SA: r = {1'b1, sa_r};
      fgen_pkg::IDX_YELLOW: r = {1'b1, yel_r};
      fgen_pkg::IDX_OVERRIDE: r = {1'b1, ovr_r};
      fgen_pkg::IDX_IRQ_EN: r = {1'b1, irqen_r};
      fgen_pkg::IDX_IRQ_FLAG: r = {1'b1, flags};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // write address and data are taken in either order; a write lands
  // one cycle after both are held, on the same edge that raises the response
  always_comb begin
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_aw_idx = aw_idx;
    next_aw_hit = aw_hit;
    next_wbyte = wbyte;
    next_wen = wen;
    next_bvalid = bvalid & ~S_AXI_BREADY;
    next_bresp = bresp;
    next_rvalid = rvalid & ~S_AXI_RREADY;
    next_rdata = rdata;
    next_rresp = rresp;
    next_fmt = fmt_r;
    next_mode = mode_r;
    next_clo = clo_r;
    next_mchi = mchi_r;
    next_sa = sa_r;
    next_yel = yel_r;
    next_ovr = ovr_r;
    next_irqen = irqen_r;
    flag_clr = 8'h00;
    rd_word = rd_mux(S_AXI_ARADDR[9:2]);
    aw_word = rd_mux(S_AXI_AWADDR[9:2]);
    if (S_AXI_AWVALID && awready) begin
      next_have_aw = 1'b1;
      next_aw_idx = S_AXI_AWADDR[9:2];
      next_aw_hit = ((S_AXI_AWADDR >> 10) == '0) && aw_word[8];
    end
    if (S_AXI_WVALID && wready) begin
      next_have_w = 1'b1;
      next_wbyte = S_AXI_WDATA[7:0];
      next_wen = S_AXI_WSTRB[0];
    end
    if (have_aw && have_w && !bvalid) begin
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = aw_hit ? fgen_pkg::RESP_OKAY : fgen_pkg::RESP_SLVERR;
      if (aw_hit && wen) begin
        case (aw_idx)
          fgen_pkg::IDX_FORMAT: next_fmt = wbyte & fgen_pkg::MASK_FORMAT;
          fgen_pkg::IDX_MODE: next_mode = wbyte & fgen_pkg::MASK_MODE;
          fgen_pkg::IDX_SLC_C_LO: next_clo = wbyte & fgen_pkg::MASK_SLC_C_LO;
          fgen_pkg::IDX_SLC_MC_HI: next_mchi = wbyte & fgen_pkg::MASK_SLC_HI;
          fgen_pkg::IDX_SLC_SA: next_sa = wbyte & fgen_pkg::MASK_SLC_HI;
          fgen_pkg::IDX_YELLOW: next_yel = wbyte & fgen_pkg::MASK_YELLOW;
          fgen_pkg::IDX_OVERRIDE: next_ovr = wbyte & fgen_pkg::MASK_OVERRIDE;
          fgen_pkg::IDX_IRQ_EN: next_irqen = wbyte & fgen_pkg::MASK_IRQ;
          fgen_pkg::IDX_IRQ_FLAG: flag_clr = wbyte & fgen_pkg::MASK_IRQ;
          default: flag_clr = 8'h00;
        endcase
      end
    end
    if (S_AXI_ARVALID && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word[7:0];
      next_rresp = ((S_AXI_ARADDR >> 10) == '0) && rd_word[8] ?
                   fgen_pkg::RESP_OKAY : fgen_pkg::RESP_SLVERR;
    end
    next_awready = ~next_have_aw & ~next_bvalid;
    next_wready = ~next_have_w & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_idx <= 8'h00;
      aw_hit <= 1'b0;
      wbyte <= 8'h00;
      wen <= 1'b0;
      bvalid <= 1'b0;
      bresp <= fgen_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 8'h00;
      rresp <= fgen_pkg::RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      fmt_r <= fgen_pkg::RST_FORMAT;
      mode_r <= fgen_pkg::RST_MODE;
      clo_r <= fgen_pkg::RST_SLC;
      mchi_r <= fgen_pkg::RST_SLC;
      sa_r <= fgen_pkg::RST_SLC;
      yel_r <= fgen_pkg::RST_YELLOW;
      ovr_r <= fgen_pkg::RST_OVERRIDE;
      irqen_r <= fgen_pkg::RST_IRQ_EN;
    end else begin
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      aw_idx <= next_aw_idx;
      aw_hit <= next_aw_hit;
      wbyte <= next_wbyte;
      wen <= next_wen;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      fmt_r <= next_fmt;
      mode_r <= next_mode;
      clo_r <= next_clo;
      mchi_r <= next_mchi;
      sa_r <= next_sa;
      yel_r <= next_yel;
      ovr_r <= next_ovr;
      irqen_r <= next_irqen;
    end
  end

  assign S_AXI_AWREADY = awready;
  assign S_AXI_WREADY = wready;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = arready;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = {24'h000000, rdata};

  // ------------------------------------------------------------
  // red alarm synchroniser
  // ------------------------------------------------------------
  logic red_s1, red_s2;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      red_s1 <= 1'b0;
      red_s2 <= 1'b0;
    end else begin
      red_s1 <= RX_RED;
      red_s2 <= red_s1;
    end
  end

  // ------------------------------------------------------------
  // frame generator
  // ------------------------------------------------------------
  logic [7:0] bit_pos, next_bit_pos;
  logic [6:0] frame, next_frame, last_frm;
  logic [5:0] crc_prev, next_crc_prev, crc_val, half;
  logic [3:0] dl_idx, next_dl_idx;
  logic [10:0] conc;
  logic [15:0] dl_code;
  logic [7:0] next_flags;
  logic slip_pend, next_slip_pend, slip_prev, last_f, next_last_f;
  logic out_data, next_out_data, out_stb, int_q, next_int;
  logic frame_en, dl_byp, is_f, yel_on, dl_src, fval, pay, crc_start;
  fgen_pkg::format_e fmt;

  assign fmt = fgen_pkg::format_e'(fmt_r[1:0]);
  assign frame_en = ~mode_r[fgen_pkg::B_FRAME_GEN_DISABLE];
  assign dl_byp = mode_r[fgen_pkg::B_DL_BYPASS];
  assign is_f = (bit_pos == 8'h00);
  assign half = frame[6:1];
  assign conc = {mchi_r[2:0], clo_r};
  assign crc_start = TX_BIT_STB && is_f && (frame == 7'h00);

  // the crc covers payload with f bits taken as one
  crc6_gen u_crc (
    .clk(CLK),
    .arst_n(ARST_N),
    .en(TX_BIT_STB && (fmt == fgen_pkg::FMT_ESF)),
    .restart(crc_start),
    .din(is_f | TX_DATA),
    .crc(crc_val)
  );

  // builds one output bit per strobe; overrides are applied last so
  // force-zero and force-one win over any framing or insertion
  always_comb begin
    yel_on = yel_r[fgen_pkg::B_MAN_YEL]
             | (yel_r[fgen_pkg::B_AUTO_YEL] & red_s2);
    dl_code = yel_on ? fgen_pkg::YEL_ESF :
              (fmt_r[fgen_pkg::B_J1] ? fgen_pkg::IDLE_J1 : fgen_pkg::IDLE_T1);
    dl_src = (DL_ACTIVE && !yel_on) ? DL_BIT : dl_code[~dl_idx];
    fval = TX_DATA;
    case (fmt)
      fgen_pkg::FMT_ESF: begin
        if (!frame[0]) begin
          fval = dl_byp ? TX_DATA : dl_src;
        end else if (frame[1:0] == 2'h1) begin
          fval = mode_r[fgen_pkg::B_CRC_BYPASS] ? TX_DATA
                 : crc_prev[3'h5 - frame[4:2]];
        end else begin
          fval = fgen_pkg::FAS_PAT[frame[4:2]];
        end
      end
      fgen_pkg::FMT_SLC: begin
        if (!frame[0]) begin
          fval = ~half[0];
        end else if (half < fgen_pkg::SLC_C0) begin
          fval = fgen_pkg::SLC_SYNC[half[3:0]];
        end else if (dl_byp) begin
          fval = TX_DATA;
        end else if (half < fgen_pkg::SLC_SPARE) begin
          fval = conc[4'(half - fgen_pkg::SLC_C0)];
        end else if (half < fgen_pkg::SLC_M0) begin
          fval = 1'b0;
        end else if (half < fgen_pkg::SLC_A0) begin
          fval = mchi_r[3'(half - fgen_pkg::SLC_M0) + 3'h3];
        end else if (half < fgen_pkg::SLC_S0) begin
          fval = sa_r[1'(half - fgen_pkg::SLC_A0)];
        end else if (half < fgen_pkg::SLC_END) begin
          fval = sa_r[3'(half - fgen_pkg::SLC_S0) + 3'h2];
        end else begin
          fval = 1'b0;
        end
      end
      default: begin
        fval = frame[0] ? fgen_pkg::FS_PAT[half[2:0]] : ~half[0];
      end
    endcase
    pay = TX_DATA;
    if (bit_pos == 8'h01 && ovr_r[fgen_pkg::B_FCOPY]) begin
      pay = last_f;
    end else if (fmt == fgen_pkg::FMT_DM && bit_pos == fgen_pkg::D_BIT_POS && !dl_byp) begin
      pay = DL_BIT;
    end else if (fmt != fgen_pkg::FMT_ESF && yel_on && bit_pos[2:0] == 3'h2) begin
      pay = 1'b0;
    end
    case (fmt)
      fgen_pkg::FMT_ESF: last_frm = fgen_pkg::LAST_FRM_ESF;
      fgen_pkg::FMT_SLC: last_frm = fgen_pkg::LAST_FRM_SLC;
      default: last_frm = fgen_pkg::LAST_FRM_12;
    endcase
    next_out_data = out_data;
    next_bit_pos = bit_pos;
    next_frame = frame;
    next_dl_idx = dl_idx;
    next_last_f = last_f;
    next_crc_prev = crc_start ? crc_val : crc_prev;
    next_slip_pend = slip_pend;
    next_flags = flags & ~flag_clr;
    if (TX_BIT_STB) begin
      next_out_data = frame_en ? (is_f ? fval : pay) : TX_DATA;
      if (ovr_r[fgen_pkg::B_FORCE_ZERO]) begin
        next_out_data = 1'b0;
      end else if (ovr_r[fgen_pkg::B_FORCE_ONE]) begin
        next_out_data = 1'b1;
      end
      if (is_f) begin
        next_last_f = fval;
      end
      if (is_f && fmt == fgen_pkg::FMT_ESF && !frame[0]) begin
        next_dl_idx = dl_idx + 4'h1;
      end
      if (frame_en && is_f) begin
        next_flags[BF] = 1'b1;
        next_flags[MF] = next_flags[MF] | (frame == 7'h00);
      end
      // a pending slip holds the position once, repeating it on the line
      if (slip_pend) begin
        next_slip_pend = 1'b0;
      end else if (bit_pos >= fgen_pkg::LAST_BIT) begin
        next_bit_pos = 8'h00;
        next_frame = (frame >= last_frm) ? 7'h00 : frame + 7'h01;
      end else begin
        next_bit_pos = bit_pos + 8'h01;
      end
    end
    if (ovr_r[fgen_pkg::B_SLIP] != slip_prev) begin
      next_slip_pend = 1'b1;
    end
    next_int = ~(|(next_flags & irqen_r));
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_pos <= 8'h00;
      frame <= 7'h00;
      dl_idx <= 4'h0;
      crc_prev <= 6'h00;
      last_f <= 1'b0;
      slip_pend <= 1'b0;
      slip_prev <= 1'b0;
      flags <= fgen_pkg::RST_IRQ_FLAG;
      out_data <= 1'b0;
      out_stb <= 1'b0;
      int_q <= 1'b1;
    end else begin
      bit_pos <= next_bit_pos;
      frame <= next_frame;
      dl_idx <= next_dl_idx;
      crc_prev <= next_crc_prev;
      last_f <= next_last_f;
      slip_pend <= next_slip_pend;
      slip_prev <= ovr_r[fgen_pkg::B_SLIP];
      flags <= next_flags;
      out_data <= next_out_data;
      out_stb <= TX_BIT_STB;
      int_q <= next_int;
    end
  end

  assign TX_LINE_DATA = out_data;
  assign TX_LINE_STB = out_stb;
  assign INT_N = int_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_FORCE_ZERO: assert property (
    TX_BIT_STB && ovr_r[fgen_pkg::B_FORCE_ZERO] |=> TX_LINE_STB && !TX_LINE_DATA)
    else $error("force zero not applied");
  AST_FORCE_ONE: assert property (
    TX_BIT_STB && ovr_r[1:0] == 2'h1 |=> TX_LINE_STB && TX_LINE_DATA)
    else $error("force one not applied");
  AST_DISABLE_PASS: assert property (
    TX_BIT_STB && !frame_en && ovr_r[1:0] == 2'h0 |=> TX_LINE_DATA == $past(TX_DATA))
    else $error("disabled generator altered data");
  AST_MIMIC: assert property (
    TX_BIT_STB && frame_en && bit_pos == 8'h01 && ovr_r[fgen_pkg::B_FCOPY]
    && ovr_r[1:0] == 2'h0 |=> TX_LINE_DATA == last_f)
    else $error("mimic bit differs from f bit");
  AST_DM_DBIT: assert property (
    TX_BIT_STB && frame_en && fmt == fgen_pkg::FMT_DM && !dl_byp && ovr_r[1:0] == 2'h0
    && bit_pos == fgen_pkg::D_BIT_POS |=> TX_LINE_DATA == $past(DL_BIT))
    else $error("d bit not replaced");
  AST_YELLOW: assert property (
    TX_BIT_STB && frame_en && fmt != fgen_pkg::FMT_ESF && bit_pos[2:0] == 3'h2 && ovr_r[1:0] == 2'h0
    && (yel_r[fgen_pkg::B_MAN_YEL] || yel_r[fgen_pkg::B_AUTO_YEL] && red_s2)
    |=> !TX_LINE_DATA)
    else $error("yellow bit not cleared");
  AST_SLIP_ARM: assert property (
    $changed(ovr_r[fgen_pkg::B_SLIP]) |=> slip_pend)
    else $error("slip toggle not armed");
  AST_SLIP_HOLD: assert property (
    TX_BIT_STB && slip_pend |=> $stable(bit_pos) && $stable(frame))
    else $error("slip did not hold alignment");
  AST_MF_SET: assert property (
    TX_BIT_STB && frame_en && is_f && frame == 7'h00 |=> flags[MF])
    else $error("multiframe flag not set");
  AST_BF_SET: assert property (
    TX_BIT_STB && frame_en && is_f |=> flags[BF])
    else $error("basic frame flag not set");
  AST_IRQ: assert property (
    ##1 INT_N == !(flags[MF] && $past(irqen_r[MF]) || flags[BF] && $past(irqen_r[BF])))
    else $error("interrupt output wrong");

  COV_MF: cover property (TX_BIT_STB && is_f && frame == 7'h00 && frame_en);
  COV_SLIP: cover property (TX_BIT_STB && slip_pend);
  COV_IRQ: cover property ($fell(INT_N));
  COV_CRC: cover property (crc_start && fmt == fgen_pkg::FMT_ESF);
endmodule
`default_nettype wire

/* sim/line_rx_model.sv */
// far-end line receiver model that tallies the received line bits
`timescale 1ns/10ps
`default_nettype none
module line_rx_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic line_data,
  input wire logic line_stb,
  output logic [15:0] n_bits,
  output logic [15:0] n_ones
);
  // count strobed bits only; clr opens a fresh window so each test stands alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n_bits <= 16'h0;
      n_ones <= 16'h0;
    end else if (clr) begin
      n_bits <= 16'h0;
      n_ones <= 16'h0;
    end else if (line_stb) begin
      n_bits <= n_bits + 16'h1;
      n_ones <= n_ones + {15'h0, line_data};
    end
  end
endmodule
`default_nettype wire

/* sim/tb_t1_transmit_frame_generator_control.sv */
// self-checking bench for the t1 transmit frame generator
`timescale 1ns/10ps
`default_nettype none
module tb_t1_transmit_frame_generator_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic stb = 1'b0, txd = 1'b0, rx_red = 1'b0, clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, line_d, line_s, int_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] n_bits, n_ones;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] yv [4] = '{8'h10, 8'h20, 8'h20, 8'h00};
  logic rv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  // ----------------------------------------
  // clock, design and far-end model
  // ----------------------------------------
  always #4 clk = ~clk;
  t1_frame_gen dut (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TX_BIT_STB(stb), .TX_DATA(txd), .DL_BIT(1'b0),
    .DL_ACTIVE(1'b0), .RX_RED(rx_red), .TX_LINE_DATA(line_d),
    .TX_LINE_STB(line_s), .INT_N(int_n));
  line_rx_model far (.clk(clk), .arst_n(arst_n), .clr(clr), .line_data(line_d),
    .line_stb(line_s), .n_bits(n_bits), .n_ones(n_ones));

  // ----------------------------------------
  // compare, bus and stream tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data go up together; each drops only at its own ready
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && awready) begin
        a = 1'b0;
        awv <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, ed});
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // n back-to-back line bits of one value; the far end window is cleared first
  task automatic sb(input int n, input logic d);
    clr <= 1'b1;
    repeat (n) begin
      @(posedge clk);
      clr <= 1'b0;
      stb <= 1'b1;
      txd <= d;
    end
    @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // interrupt pin lags an enable write by a cycle, so let it settle first
  task automatic ck_int(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, int_n}, {31'h0, e});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 8'h62; k < 8'h6f; k++) begin
      if (k < 8'h63 || (k > 8'h64 && k < 8'h68) || k > 8'h6a) rd(k[7:0], 8'h00, 2'h0);
    end
    wr(fgen_pkg::IDX_MODE, 8'hff, fgen_pkg::RESP_OKAY);
    rd(fgen_pkg::IDX_MODE, 8'h07, fgen_pkg::RESP_OKAY);
    rd(8'h70, 8'h00, fgen_pkg::RESP_SLVERR);
    wr(8'h70, 8'h55, fgen_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(fgen_pkg::IDX_MODE, 8'h01, fgen_pkg::RESP_OKAY);
    sb(193, 1'b1);
    chk({16'h0, n_ones}, 32'd193);
    rd(fgen_pkg::IDX_IRQ_FLAG, 8'h00, fgen_pkg::RESP_OKAY);
    wr(fgen_pkg::IDX_OVERRIDE, 8'h03, fgen_pkg::RESP_OKAY);
    sb(100, 1'b1);
    chk({n_bits, n_ones}, {16'd100, 16'd0});
    wr(fgen_pkg::IDX_OVERRIDE, 8'h01, fgen_pkg::RESP_OKAY);
    sb(100, 1'b0);
    chk({n_bits, n_ones}, {16'd100, 16'd100});
    wr(fgen_pkg::IDX_OVERRIDE, 8'h00, fgen_pkg::RESP_OKAY);
    $display("test overrides done");
    wr(fgen_pkg::IDX_MODE, 8'h00, fgen_pkg::RESP_OKAY);
    wr(fgen_pkg::IDX_IRQ_EN, 8'h10, fgen_pkg::RESP_OKAY);
    ck_int(1'b1);
    sb(12 * 193, 1'b1);
    ck_int(1'b0);
    rd(fgen_pkg::IDX_IRQ_FLAG, 8'h30, fgen_pkg::RESP_OKAY);
    wr(fgen_pkg::IDX_IRQ_FLAG, 8'h10, fgen_pkg::RESP_OKAY);
    ck_int(1'b1);
    wr(fgen_pkg::IDX_IRQ_EN, 8'h20, fgen_pkg::RESP_OKAY);
    ck_int(1'b0);
    wr(fgen_pkg::IDX_IRQ_FLAG, 8'h20, fgen_pkg::RESP_OKAY);
    ck_int(1'b1);
    rd(fgen_pkg::IDX_IRQ_FLAG, 8'h00, fgen_pkg::RESP_OKAY);
    $display("test interrupts done");
    for (int k = 0; k < 4; k++) begin
      wr(fgen_pkg::IDX_YELLOW, yv[k], fgen_pkg::RESP_OKAY);
      rx_red <= rv[k];
      repeat (4) @(posedge clk);
      sb(193, 1'b1);
      chk({31'h0, n_ones >= (k < 2 ? 168 : 192) && n_ones <= (k < 2 ? 169 : 193)}, 1);
    end
    $display("test yellow done");
    sb(186, 1'b1);
    wr(fgen_pkg::IDX_OVERRIDE, 8'h04, fgen_pkg::RESP_OKAY);
    sb(1, 1'b1);
    wr(fgen_pkg::IDX_IRQ_FLAG, 8'h30, fgen_pkg::RESP_OKAY);
    sb(1, 1'b1);
    rd(fgen_pkg::IDX_IRQ_FLAG, 8'h10, fgen_pkg::RESP_OKAY);
    wr(fgen_pkg::IDX_OVERRIDE, 8'h0c, fgen_pkg::RESP_OKAY);
    sb(192, 1'b0);
    chk({n_bits, n_ones}, {16'd192, 16'd1});
    wr(fgen_pkg::IDX_FORMAT, 8'h02, fgen_pkg::RESP_OKAY);
    wr(fgen_pkg::IDX_OVERRIDE, 8'h04, fgen_pkg::RESP_OKAY);
    sb(193, 1'b1);
    chk({n_bits, n_ones}, {16'd193, 16'd192});
    $display("test slip, mimic and d bit done");
    print_verdict();
  end

  // watchdog: the tests need about 4300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
